// File: rtl/pmc_power_mode_control.v
// power mode controller: idle, stop and suspend sequencing
`include "pmc_defs.vh"
module pmc_power_mode_control
(
   input  wire        clk_i,          // system clock
   input  wire        arst_n_i,       // async reset, active low
   input  wire        ce_i,           // clock enable
   input  wire        pwr_we_i,       // power_control_reg write strobe
   input  wire [7:0]  pwr_wdata_i,    // power_control_reg write data
   input  wire        osc_we_i,       // internal_osc_control_reg write strobe
   input  wire [7:0]  osc_wdata_i,    // internal_osc_control_reg write data
   input  wire        instr_done_i,   // writing instruction completed
   input  wire        irq_pending_i,  // enabled interrupt asserted
   input  wire        wdog_enable_i,  // watchdog_timer enabled
   input  wire        wdog_expire_i,  // watchdog_timer expiry
   input  wire        port_match_i,   // async port match wake
   input  wire        cmp_low_i,      // async comparator low wake
   input  wire        osc_ready_i,    // internal oscillator stable
   input  wire        analog_en_i,    // software analog enables
   output wire [7:0]  pwr_rdata_o,    // power_control_reg read value
   output wire [7:0]  osc_rdata_o,    // internal_osc_control_reg read value
   output reg         cpu_halt_o,     // cpu halted
   output reg         int_osc_en_o,   // internal oscillator enable
   output reg         periph_clk_en_o,// peripheral and timer clock enable
   output reg         irq_en_o,       // interrupt logic active
   output wire        mcd_en_o,       // missing clock detector active
   output wire        ext_osc_hold_o, // external oscillator left as is
   output wire        analog_en_o,    // analog enable passthrough
   output reg         wdog_run_o,     // watchdog counting
   output reg         wdog_reset_o,   // watchdog reset request
   output reg  [15:0] resume_pc_sel_o,// reset vector on reset resume
   output reg  [2:0]  mode_o          // one-hot: suspend, stop, idle; all zero in run
);
   localparam [3:0] ST_RUN  = 4'h1;
   localparam [3:0] ST_IDLE = 4'h2;
   localparam [3:0] ST_STOP = 4'h4;
   localparam [3:0] ST_SUSP = 4'h8;
   localparam [7:0] RESTART_CYC = `PMC_OSC_RESTART_CYC;

   reg  [3:0] state_q;
   reg  [7:0] pwr_q;
   reg  [7:0] osc_q;
   reg        idle_req_q;
   reg        stop_req_q;
   reg  [7:0] restart_q;
   wire       port_match_s;
   wire       cmp_low_s;

   pmc_sync u_sync_pm
   (
      .clk_i    (clk_i),
      .arst_n_i (arst_n_i),
      .ce_i     (ce_i),
      .d_i      (port_match_i),
      .q_o      (port_match_s)
   );

   pmc_sync u_sync_cmp
   (
      .clk_i    (clk_i),
      .arst_n_i (arst_n_i),
      .ce_i     (ce_i),
      .d_i      (cmp_low_i),
      .q_o      (cmp_low_s)
   );

   assign pwr_rdata_o    = pwr_q;
   assign osc_rdata_o    = osc_q;
   assign mcd_en_o       = 1'b1;
   assign ext_osc_hold_o = 1'b1;
   assign analog_en_o    = analog_en_i;

   wire suspend_wake = port_match_s | cmp_low_s;

   always @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         state_q    <= ST_RUN;
         pwr_q      <= `PMC_PWR_RST;
         osc_q      <= `PMC_OSC_RST;
         idle_req_q <= 1'b0;
         stop_req_q <= 1'b0;
         restart_q  <= 8'h00;
         wdog_reset_o <= 1'b0;
      end
      else if (ce_i)
      begin
         wdog_reset_o <= wdog_enable_i & wdog_expire_i & state_q[1];
         case (state_q)
            ST_RUN:
            begin
               if (pwr_we_i)
               begin
                  pwr_q      <= pwr_wdata_i;
                  idle_req_q <= pwr_wdata_i[`PMC_PWR_IDLE_BIT];
                  stop_req_q <= pwr_wdata_i[`PMC_PWR_STOP_BIT];
               end
               if (osc_we_i)
               begin
                  osc_q <= osc_wdata_i;
                  if (osc_wdata_i[`PMC_OSC_SUSPEND_BIT])
                     state_q <= ST_SUSP;
               end
               else if (instr_done_i && stop_req_q)
               begin
                  state_q    <= ST_STOP;
                  stop_req_q <= 1'b0;
                  idle_req_q <= 1'b0;
               end
               else if (instr_done_i && idle_req_q)
               begin
                  idle_req_q <= 1'b0;
                  if (irq_pending_i)
                     pwr_q[`PMC_PWR_IDLE_BIT] <= 1'b0;
                  else
                     state_q <= ST_IDLE;
               end
            end
            ST_IDLE:
            begin
               if (irq_pending_i)
               begin
                  pwr_q[`PMC_PWR_IDLE_BIT] <= 1'b0;
                  state_q <= ST_RUN;
               end
            end
            ST_STOP:
               state_q <= ST_STOP;
            ST_SUSP:
            begin
               if (restart_q != 8'h00)
               begin
                  if (osc_ready_i && restart_q == 8'h01)
                  begin
                     osc_q[`PMC_OSC_SUSPEND_BIT] <= 1'b0;
                     state_q   <= ST_RUN;
                     restart_q <= 8'h00;
                  end
                  else if (restart_q != 8'h01)
                     restart_q <= restart_q - 8'h01;
               end
               else if (suspend_wake)
                  restart_q <= RESTART_CYC;
            end
            default:
               state_q <= ST_RUN;
         endcase
      end
   end

   always @*
   begin
      cpu_halt_o      = 1'b0;
      int_osc_en_o    = 1'b1;
      periph_clk_en_o = 1'b1;
      irq_en_o        = 1'b1;
      wdog_run_o      = wdog_enable_i;
      resume_pc_sel_o = `PMC_RESET_VECTOR;
      mode_o          = 3'b000;
      case (state_q)
         ST_RUN:
            mode_o = 3'b000;
         ST_IDLE:
         begin
            cpu_halt_o = 1'b1;
            mode_o     = 3'b001;
         end
         ST_STOP:
         begin
            cpu_halt_o      = 1'b1;
            int_osc_en_o    = 1'b0;
            periph_clk_en_o = 1'b0;
            irq_en_o        = 1'b0;
            wdog_run_o      = 1'b0;
            mode_o          = 3'b010;
         end
         ST_SUSP:
         begin
            cpu_halt_o      = 1'b1;
            int_osc_en_o    = (restart_q != 8'h00);
            periph_clk_en_o = 1'b0;
            wdog_run_o      = 1'b0;
            mode_o          = 3'b100;
         end
         default:
            mode_o = 3'b000;
      endcase
   end
endmodule // pmc_power_mode_control

// File: rtl/pmc_defs.vh
// constants for the power mode controller
`ifndef PMC_DEFS_VH
`define PMC_DEFS_VH
`define PMC_PWR_IDLE_BIT     0
`define PMC_PWR_STOP_BIT     1
`define PMC_OSC_SUSPEND_BIT  5
`define PMC_PWR_RST          8'h00
`define PMC_OSC_RST          8'h00
`define PMC_RESET_VECTOR     16'h0000
`define PMC_OSC_RESTART_NS   100
`define PMC_CLK_NS           10
// restart time in clock cycles, sized to the restart counter
`define PMC_OSC_RESTART_CYC  8'h0a
`endif

// File: rtl/pmc_sync.v
// three-stage synchroniser with second/third agreement
module pmc_sync
(
   input  wire clk_i,    // system clock
   input  wire arst_n_i, // async reset, active low
   input  wire ce_i,     // clock enable
   input  wire d_i,      // asynchronous input
   output reg  q_o       // filtered level
);
   reg s1_q;
   reg s2_q;
   reg s3_q;

   always @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
         q_o  <= 1'b0;
      end
      else if (ce_i)
      begin
         s1_q <= d_i;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q)
            q_o <= s3_q;
      end
   end
endmodule // pmc_sync

// File: sim/pmc_chk.sv
// assertions on the power mode controller ports
module pmc_chk
(
   input logic clk_i, arst_n_i, ce_i, pwr_we_i, osc_we_i, instr_done_i, irq_pending_i,
   input logic wdog_enable_i, wdog_expire_i, analog_en_i, analog_en_o, wdog_reset_o,
   input logic cpu_halt_o, int_osc_en_o, periph_clk_en_o, irq_en_o, mcd_en_o,
   input logic [7:0] pwr_wdata_i, pwr_rdata_o,
   input logic [15:0] resume_pc_sel_o,
   input logic [2:0] mode_o
);
   default clocking @(posedge clk_i);
   endclocking
   default disable iff (!arst_n_i);
   sequence idle_req_s;
      pwr_we_i && pwr_wdata_i == 8'h01 && mode_o == 3'b000 && !osc_we_i && ce_i;
   endsequence
   sequence instr_end_s;
      instr_done_i && !irq_pending_i && !osc_we_i && ce_i;
   endsequence
   idle_entry_a: assert property (idle_req_s ##1 instr_end_s |=> mode_o == 3'b001)
      else $error("idle not entered");
   idle_clocks_a: assert property (mode_o == 3'b001 |->
      cpu_halt_o && int_osc_en_o && periph_clk_en_o && irq_en_o) else $error("idle gating");
   stop_gating_a: assert property (mode_o == 3'b010 |->
      cpu_halt_o && !int_osc_en_o && !periph_clk_en_o && !irq_en_o && mcd_en_o)
      else $error("stop gating");
   stop_hold_a: assert property (mode_o == 3'b010 |=> $stable(mode_o))
      else $error("stop left without reset");
   idle_exit_a: assert property (mode_o == 3'b001 && irq_pending_i && ce_i |=>
      !cpu_halt_o && !pwr_rdata_o[0]) else $error("idle not left on interrupt");
   wdog_reset_a: assert property (mode_o == 3'b001 && wdog_enable_i && wdog_expire_i && ce_i
      |=> wdog_reset_o) else $error("no watchdog reset");
   analog_pass_a: assert property (analog_en_o == analog_en_i)
      else $error("analog enable changed");
   reset_vector_a: assert property (resume_pc_sel_o == 16'h0000)
      else $error("bad reset vector");
endmodule // pmc_chk
bind pmc_power_mode_control pmc_chk u_pmc_chk (.clk_i, .arst_n_i, .ce_i, .pwr_we_i, .osc_we_i,
   .instr_done_i, .irq_pending_i, .wdog_enable_i, .wdog_expire_i, .analog_en_i, .analog_en_o,
   .wdog_reset_o, .cpu_halt_o, .int_osc_en_o, .periph_clk_en_o, .irq_en_o, .mcd_en_o,
   .pwr_wdata_i, .pwr_rdata_o, .resume_pc_sel_o, .mode_o);

// File: sim/test_power_mode_control.sv
// self-checking bench for the power mode controller
module test_power_mode_control;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 0, arst_n_i = 0, ce_i = 1, pwr_we_i = 0, osc_we_i = 0, instr_done_i = 0;
   logic irq_pending_i = 0, wdog_enable_i = 0, wdog_expire_i = 0, port_match_i = 0, cmp_low_i = 0;
   logic osc_ready_i = 0, analog_en_i = 0, cpu_halt_o, int_osc_en_o, periph_clk_en_o, irq_en_o;
   logic mcd_en_o, ext_osc_hold_o, analog_en_o, wdog_run_o, wdog_reset_o;
   logic [7:0] pwr_wdata_i = 8'h00, osc_wdata_i = 8'h00, pwr_rdata_o, osc_rdata_o;
   logic [15:0] resume_pc_sel_o;
   logic [2:0] mode_o, em;
   logic [31:0] rs = 32'd71898;
   int error_cnt = 0, checks = 0;
   pmc_power_mode_control u_pmc_power_mode_control (.clk_i, .arst_n_i, .ce_i, .pwr_we_i,
      .pwr_wdata_i, .osc_we_i, .osc_wdata_i, .instr_done_i, .irq_pending_i, .wdog_enable_i,
      .wdog_expire_i, .port_match_i, .cmp_low_i, .osc_ready_i, .analog_en_i, .pwr_rdata_o,
      .osc_rdata_o, .cpu_halt_o, .int_osc_en_o, .periph_clk_en_o, .irq_en_o, .mcd_en_o,
      .ext_osc_hold_o, .analog_en_o, .wdog_run_o, .wdog_reset_o, .resume_pc_sel_o, .mode_o);
   always #5 clk_i = ~clk_i;
   function logic [31:0] xs();
      rs = rs ^ (rs << 13);
      rs = rs ^ (rs >> 17);
      rs = rs ^ (rs << 5);
      return rs;
   endfunction
   task chk(input logic [15:0] g, input logic [15:0] e);
      checks++;
      error_cnt += (g !== e);
      if (g !== e)
         $display("ERROR %0t got %h exp %h", $time, g, e);
   endtask
   task rst;
      @(posedge clk_i);
      arst_n_i <= 0;
      @(posedge clk_i);
      arst_n_i <= 1;
      em = 0;
      #1;
   endtask
   // sel 0: power control write then instruction end, sel 1: oscillator control write
   task enter(input logic sel, input logic [7:0] d);
      @(posedge clk_i);
      {pwr_we_i, osc_we_i, pwr_wdata_i, osc_wdata_i} <= {!sel, sel, d, d};
      @(posedge clk_i);
      // power control write ends with a separate completion cycle; oscillator control write has none
      {pwr_we_i, osc_we_i, instr_done_i} <= {2'b00, !sel};
      @(posedge clk_i);
      instr_done_i <= 0;
      #1;
   endtask
   task test_done;
      $display("checks %0d errors %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial
   begin
      rst;
      chk({pwr_rdata_o, osc_rdata_o}, 16'h0000);
      chk({mode_o, cpu_halt_o, int_osc_en_o}, 5'b00001);
      enter(0, 8'h01);
      em = 1;
      chk({mode_o, periph_clk_en_o, irq_en_o}, {em, 2'b11});
      repeat (xs() % 8 + 2)
      begin
         @(posedge clk_i);
         analog_en_i <= xs() > 32'h7fffffff;
         #1 chk(mode_o, em);
         chk(analog_en_o, analog_en_i);
      end
      enter(0, 8'h02);
      chk({mode_o, pwr_rdata_o}, {em, 8'h01});
      @(posedge clk_i);
      irq_pending_i <= 1;
      @(posedge clk_i);
      irq_pending_i <= 0;
      em = 0;
      #1 chk({mode_o, cpu_halt_o, pwr_rdata_o}, {em, 9'h000});
      $display("test idle done");
      wdog_enable_i <= 1;
      enter(0, 8'h01);
      chk(wdog_run_o, 1'b1);
      wdog_expire_i <= 1;
      @(posedge clk_i);
      wdog_expire_i <= 0;
      #1 chk(wdog_reset_o, 1'b1);
      rst;
      wdog_enable_i <= 0;
      chk({mode_o, cpu_halt_o, resume_pc_sel_o[11:0]}, 16'h0000);
      $display("test watchdog done");
      enter(0, 8'h02);
      em = 2;
      chk({mode_o, cpu_halt_o, int_osc_en_o, periph_clk_en_o}, {em, 3'b100});
      chk({irq_en_o, mcd_en_o, ext_osc_hold_o}, 3'b011);
      chk(wdog_run_o, 1'b0);
      irq_pending_i <= 1;
      repeat (3) @(posedge clk_i);
      irq_pending_i <= 0;
      #1 chk(mode_o, em);
      rst;
      chk(mode_o, em);
      $display("test stop done");
      for (int w = 0; w < 2; w++)
      begin
         enter(1, 8'h20);
         em = 4;
         chk({mode_o, int_osc_en_o, cpu_halt_o, osc_rdata_o}, {em, 2'b01, 8'h20});
         {port_match_i, cmp_low_i, osc_ready_i} <= {w == 0, w == 1, 1'b1};
         for (int k = 0; k < 40 && mode_o === 3'b100; k++)
            @(posedge clk_i);
         {port_match_i, cmp_low_i, osc_ready_i} <= 3'b000;
         em = 0;
         #1 chk({mode_o, int_osc_en_o, cpu_halt_o, osc_rdata_o}, {em, 2'b10, 8'h00});
         // let the wake synchroniser drain before the next entry
         repeat (6) @(posedge clk_i);
      end
      $display("test suspend done");
      test_done;
   end
   initial
   begin
      #20000;
      error_cnt++;
      test_done;
   end
endmodule // test_power_mode_control
